//--- rtl/cipu_regs.svh
/*
  Constants for the processor interrupt priority unit: fixed addresses,
  mask bit positions, condition bit positions and cause codes.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef CIPU_REGS_SVH
`define CIPU_REGS_SVH

`define CIPU_MASK_W 12
`define CIPU_COND_W 6
`define CIPU_MASK_RST 12'h000
`define CIPU_COND_RST 6'h00
`define CIPU_RET_ADDR 15'h0004
`define CIPU_CODE_ADDR 15'h0005
`define CIPU_MB_RTC 8
`define CIPU_MB_EXPBCD 9
`define CIPU_MB_ARITH 10
`define CIPU_MB_SRCH 11
`define CIPU_CB_BJMP 0
`define CIPU_CB_DLOAD 1
`define CIPU_CB_RELOC 2
`define CIPU_CB_PJMP 3
`define CIPU_CB_IEN 4
`define CIPU_CB_PSTATE 5
`define CIPU_CODE_CHAN 12'h040
`define CIPU_CODE_INTB 12'h048

`endif

//--- rtl/cipu_pkg.sv
/*
  Types for the processor interrupt priority unit.
  Assumes the constant header is on the include path.
*/
package cipu_pkg;
  `include "cipu_regs.svh"

  typedef struct packed {
    logic arith_ovf;
    logic divide;
    logic exponent;
    logic bcd;
    logic srch_move;
    logic rtc;
    logic manual;
    logic assoc;
  } cipu_int_t;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
    logic [11:0] code;
  } cipu_entry_t;

  typedef enum logic [1:0] {
    CIPU_IDLE = 2'b00,
    CIPU_SAVE = 2'b01,
    CIPU_CODE = 2'b10
  } cipu_state_t;
endpackage

//--- rtl/cipu_unit.sv
/*
  Processor interrupt priority unit: scan, mask, clear, sense, entry
  sequence and executive condition register.
  Assumes the sequencer gives one-cycle operation pulses on i_mclk and
  holds the recognition point until o_entry_done; channel lines come
  from pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "cipu_regs.svh"

module cipu_unit
  import cipu_pkg::*;
#(
  parameter int N_CHAN = 8,
  parameter int N_LINE = 8
)(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [63:0] i_equip_line,
  input wire logic [7:0] i_chan_int,
  input wire logic [7:0] i_chan_present,
  input wire cipu_int_t i_int_event,
  input wire logic i_exec_int,
  input wire logic i_master_clear_request,
  input wire logic i_internal_clear_request,
  input wire logic i_external_clear_request,
  input wire logic i_recog_point,
  input wire logic i_trap_exit_jump,
  input wire logic [14:0] i_pc,
  input wire logic [11:0] i_op_mask,
  input wire logic i_mask_set_op,
  input wire logic i_mask_clear_op,
  input wire logic i_interrupt_sense_op,
  input wire logic i_internal_sense_op,
  input wire logic i_combined_sense_op,
  input wire logic i_clear_all_op,
  input wire logic i_io_clear_op,
  input wire logic i_channel_clear_op,
  input wire logic i_equip_select_op,
  input wire logic [5:0] i_equip_sel_idx,
  input wire logic i_irq_enable_op,
  input wire logic i_irq_disable_op,
  input wire logic i_cond_to_acc_op,
  input wire logic i_acc_to_cond_op,
  input wire logic [5:0] i_acc_cond,
  input wire logic i_boundary_jump_set_op,
  input wire logic i_destructive_load_set_op,
  input wire logic i_relocate_operands_op,
  input wire logic i_relocation_off_op,
  input wire logic i_load_acc_op,
  input wire logic i_jump_op,
  input wire logic i_jump_to_program,
  output logic [23:0] o_acc_data,
  output logic [63:0] o_sense_equip,
  output logic [7:0] o_sense_chan,
  output logic [11:0] o_mask,
  output logic [5:0] o_cond,
  output logic o_irq_enabled,
  output logic o_monitor_state,
  output logic o_int_pending,
  output cipu_entry_t o_mem_write,
  output logic [11:0] o_mem_bitmask,
  output logic o_entry_done
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (N_CHAN != 8 || N_LINE != 8)
  begin : g_bad_size
    $error("cipu_unit serves eight channels of eight lines only");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [63:0] eq_s1_reg, eq_s2_reg;
  logic [7:0] ch_s1_reg, ch_s2_reg;
  always_ff @(posedge i_mclk)
  begin
    eq_s1_reg <= i_equip_line;
    eq_s2_reg <= eq_s1_reg;
    ch_s1_reg <= i_chan_int;
    ch_s2_reg <= ch_s1_reg;
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cipu_state_t state_reg;
  cipu_int_t internal_reg;
  logic [63:0] equip_reg;
  logic [7:0] chan_reg;
  logic [11:0] mask_reg;
  logic [5:0] cond_reg;
  logic blocked_reg;
  logic [11:0] code_reg;
  logic [14:0] pc_reg;
  logic take;
  logic [11:0] sel_code;
  logic sel_manual, sel_assoc;
  logic [63:0] equip_q;
  logic [7:0] chan_q;
  logic ien;

  assign ien = cond_reg[`CIPU_CB_IEN];

  // Equipment and channel pending flags; a new event beats a clear.
  genvar gi;
  for (gi = 0; gi < 64; gi++)
  begin : g_equip
    logic clr;
    assign clr = i_master_clear_request | i_external_clear_request
      | i_io_clear_op
      | (i_equip_select_op && i_equip_sel_idx == 6'(gi));
    always_ff @(posedge i_mclk)
    begin
      if (i_sys_rst)
        equip_reg[gi] <= 1'b0;
      else if (eq_s2_reg[gi])
        equip_reg[gi] <= 1'b1;
      else if (clr)
        equip_reg[gi] <= 1'b0;
    end
  end

  for (gi = 0; gi < 8; gi++)
  begin : g_chan
    always_ff @(posedge i_mclk)
    begin
      if (i_sys_rst)
        chan_reg[gi] <= 1'b0;
      else if (ch_s2_reg[gi])
        chan_reg[gi] <= 1'b1;
      else if (i_master_clear_request | i_external_clear_request
               | i_clear_all_op | i_io_clear_op | i_channel_clear_op)
        chan_reg[gi] <= 1'b0;
    end
  end

  // Internal conditions: events set, clears drop; set wins.
  cipu_int_t int_clr;
  always_comb
  begin
    int_clr = '0;
    if (i_master_clear_request | i_internal_clear_request
        | i_clear_all_op
        | i_interrupt_sense_op | i_internal_sense_op)
      int_clr = '1;
    if (i_io_clear_op)
      int_clr.srch_move = 1'b1;
    if (take && sel_manual)
      int_clr.manual = 1'b1;
    if (take && sel_assoc)
      int_clr.assoc = 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      internal_reg <= '0;
    else
      internal_reg <= i_int_event | (internal_reg & ~int_clr);
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      mask_reg <= `CIPU_MASK_RST;
    else if (i_mask_set_op)
      mask_reg <= mask_reg | i_op_mask;
    else if (i_mask_clear_op)
      mask_reg <= mask_reg & ~i_op_mask;
  end

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  // Evaluated as one cycle of logic at the recognition point, which
  // gives the same winner as walking the list from the top.
  always_comb
  begin
    logic en;
    logic [2:0] c, l;
    en = ien && !blocked_reg;
    sel_code = 12'h000;
    sel_manual = 1'b0;
    sel_assoc = 1'b0;
    take = 1'b0;
    c = 3'h0;
    l = 3'h0;
    equip_q = '0;
    chan_q = '0;
    for (int ch = 0; ch < 8; ch++)
    begin
      for (int ln = 0; ln < 8; ln++)
        equip_q[ch*8+ln] = equip_reg[ch*8+ln] & mask_reg[ch];
      chan_q[ch] = chan_reg[ch] & mask_reg[ch];
    end
    if (i_exec_int && !blocked_reg)
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h00F;
    end
    else if (en && internal_reg.arith_ovf && mask_reg[`CIPU_MB_ARITH])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h000;
    end
    else if (en && internal_reg.divide && mask_reg[`CIPU_MB_ARITH])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h001;
    end
    else if (en && internal_reg.exponent && mask_reg[`CIPU_MB_EXPBCD])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h002;
    end
    else if (en && internal_reg.bcd && mask_reg[`CIPU_MB_EXPBCD])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h003;
    end
    else if (en && |equip_q)
    begin
      take = 1'b1;
      for (int i = 63; i >= 0; i--)
        if (equip_q[i])
        begin
          c = 3'(i / 8);
          l = 3'(i % 8);
        end
      sel_code = {6'h00, l, c};
    end
    else if (en && |chan_q)
    begin
      take = 1'b1;
      for (int i = 7; i >= 0; i--)
        if (chan_q[i])
          c = 3'(i);
      sel_code = `CIPU_CODE_CHAN | {9'h000, c};
    end
    else if (en && internal_reg.srch_move && mask_reg[`CIPU_MB_SRCH])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h004;
    end
    else if (en && internal_reg.rtc && mask_reg[`CIPU_MB_RTC])
    begin
      take = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h005;
    end
    else if (en && internal_reg.manual)
    begin
      take = 1'b1;
      sel_manual = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h006;
    end
    else if (en && internal_reg.assoc)
    begin
      take = 1'b1;
      sel_assoc = 1'b1;
      sel_code = `CIPU_CODE_INTB + 12'h007;
    end
    take = take && i_recog_point && state_reg == CIPU_IDLE;
  end

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= CIPU_IDLE;
      code_reg <= 12'h000;
      pc_reg <= 15'h0000;
    end
    else
    begin
      unique case (state_reg)
        CIPU_IDLE:
          if (take)
          begin
            state_reg <= CIPU_SAVE;
            code_reg <= sel_code;
            pc_reg <= i_pc;
          end
        CIPU_SAVE:
          state_reg <= CIPU_CODE;
        CIPU_CODE:
          state_reg <= CIPU_IDLE;
        default:
          state_reg <= CIPU_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_mem_write <= '0;
      o_mem_bitmask <= 12'h000;
      o_entry_done <= 1'b0;
    end
    else
    begin
      o_mem_write <= '0;
      o_mem_bitmask <= 12'h000;
      o_entry_done <= 1'b0;
      if (state_reg == CIPU_SAVE)
        o_mem_write <= '{1'b1, `CIPU_RET_ADDR, pc_reg[11:0]};
      if (state_reg == CIPU_CODE)
      begin
        o_mem_write <= '{1'b1, `CIPU_CODE_ADDR, code_reg};
        o_mem_bitmask <= 12'hFFF;
        o_entry_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Condition register and recognition block
  // ----------------------------------------------------------------
  // Blocking holds from recognition to the save op, and from the
  // restore op to the exit jump.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      blocked_reg <= 1'b0;
    else if (take || i_acc_to_cond_op)
      blocked_reg <= 1'b1;
    else if (i_cond_to_acc_op || i_trap_exit_jump)
      blocked_reg <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      cond_reg <= `CIPU_COND_RST;
    else if (take)
    begin
      cond_reg[`CIPU_CB_IEN] <= 1'b0;
      cond_reg[`CIPU_CB_PSTATE] <= 1'b0;
    end
    else if (i_cond_to_acc_op)
      cond_reg <= `CIPU_COND_RST;
    else if (i_acc_to_cond_op)
      cond_reg <= i_acc_cond;
    else if (!blocked_reg)
    begin
      if (i_boundary_jump_set_op)
        cond_reg[`CIPU_CB_BJMP] <= 1'b1;
      else if (i_jump_op)
        cond_reg[`CIPU_CB_BJMP] <= 1'b0;
      if (i_destructive_load_set_op)
        cond_reg[`CIPU_CB_DLOAD] <= 1'b1;
      else if (i_load_acc_op)
        cond_reg[`CIPU_CB_DLOAD] <= 1'b0;
      if (i_relocate_operands_op)
        cond_reg[`CIPU_CB_RELOC] <= 1'b1;
      else if (i_relocation_off_op)
        cond_reg[`CIPU_CB_RELOC] <= 1'b0;
      if (i_jump_to_program)
      begin
        cond_reg[`CIPU_CB_PJMP] <= 1'b0;
        cond_reg[`CIPU_CB_PSTATE] <= 1'b1;
      end
      else if (i_jump_op && cond_reg[`CIPU_CB_PSTATE])
        cond_reg[`CIPU_CB_PJMP] <= 1'b1;
      if (i_irq_enable_op)
        cond_reg[`CIPU_CB_IEN] <= 1'b1;
      else if (i_irq_disable_op)
        cond_reg[`CIPU_CB_IEN] <= 1'b0;
    end
    else if (i_irq_enable_op)
      cond_reg[`CIPU_CB_IEN] <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Sense and accumulator read
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_acc_data <= 24'h000000;
      o_sense_equip <= '0;
      o_sense_chan <= 8'h00;
    end
    else
    begin
      for (int ch = 0; ch < 8; ch++)
      begin
        o_sense_equip[ch*8 +: 8] <= equip_reg[ch*8 +: 8]
          | {8{~i_chan_present[ch]}};
        o_sense_chan[ch] <= chan_reg[ch] | ~i_chan_present[ch];
      end
      if (i_combined_sense_op)
        o_acc_data <= {mask_reg, 4'h0, internal_reg};
      else if (i_internal_sense_op || i_interrupt_sense_op)
        o_acc_data <= {16'h0000, internal_reg};
      else if (i_cond_to_acc_op)
        o_acc_data <= {18'h00000, cond_reg};
    end
  end

  assign o_mask = mask_reg;
  assign o_cond = cond_reg;
  assign o_irq_enabled = ien;
  assign o_monitor_state = ~cond_reg[`CIPU_CB_PSTATE];
  assign o_int_pending = (|internal_reg) | (|equip_reg) | (|chan_reg)
    | i_exec_int;

endmodule // cipu_unit

//--- verif/cipu_chan_model.sv
/*
  Behavioural model of eight channels raising their interrupt lines.
  Assumes the bench gives the wanted line levels per channel.
*/
`timescale 1ns/1ps
module cipu_chan_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_present,
  input wire logic [63:0] i_want,
  input wire logic [7:0] i_chan_want,
  output logic [63:0] o_equip_line,
  output logic [7:0] o_chan_int
);
  logic flip = 1'b0;
  // Pins of absent channels float, so they toggle to expose any reliance.
  always_ff @(posedge i_mclk)
  begin
    flip <= ~flip;
    for (int c = 0; c < 8; c++)
    begin
      o_equip_line[c*8 +: 8] <= i_present[c] ? i_want[c*8 +: 8] : {8{flip}};
      o_chan_int[c] <= i_present[c] ? i_chan_want[c] : flip;
    end
  end
endmodule // cipu_chan_model

//--- verif/cipu_unit_props.sv
/*
  Port checker for cipu_unit.
  Assumes one clock domain; bound onto every instance below.
*/
`timescale 1ns/1ps
`include "cipu_regs.svh"
module cipu_unit_props
  import cipu_pkg::*;
#(
  parameter int N_CHAN = 8,
  parameter int N_LINE = 8
)(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_chan_present,
  input wire logic i_exec_int,
  input wire logic [14:0] i_pc,
  input wire logic [11:0] i_op_mask,
  input wire logic i_mask_set_op,
  input wire logic i_mask_clear_op,
  input wire logic i_interrupt_sense_op,
  input wire logic i_irq_enable_op,
  input wire logic i_cond_to_acc_op,
  input wire logic [63:0] o_sense_equip,
  input wire logic [11:0] o_mask,
  input wire logic [5:0] o_cond,
  input wire logic o_irq_enabled,
  input wire logic o_monitor_state,
  input wire cipu_entry_t o_mem_write,
  input wire logic [11:0] o_mem_bitmask,
  input wire logic o_entry_done
);
  logic [63:0] absent;
  logic ret_wr;
  always_comb
  begin
    for (int i = 0; i < 64; i++)
      absent[i] = ~i_chan_present[i / N_LINE];
  end
  assign ret_wr = o_mem_write.valid && o_mem_write.addr == `CIPU_RET_ADDR;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_entry_seq;
    ret_wr |=> o_mem_write.valid && o_mem_write.addr == `CIPU_CODE_ADDR
      && o_mem_bitmask == 12'hFFF && o_entry_done;
  endproperty
  a_entry_seq: assert property (p_entry_seq)
    else $error("code write missing after return write");
  property p_ret_word;
    ret_wr |-> o_mem_write.code == i_pc[11:0] && o_mem_bitmask == 12'h000;
  endproperty
  a_ret_word: assert property (p_ret_word)
    else $error("return address write wrong");
  property p_qualified;
    ret_wr |-> $past(o_irq_enabled, 2) || $past(i_exec_int, 2);
  endproperty
  a_qualified: assert property (p_qualified)
    else $error("entry while system disabled");
  property p_done_state;
    o_entry_done |-> !o_irq_enabled && o_monitor_state;
  endproperty
  a_done_state: assert property (p_done_state)
    else $error("entry left system enabled");
  property p_mask_set;
    i_mask_set_op |=> (o_mask & $past(i_op_mask)) == $past(i_op_mask);
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("mask bits not set");
  property p_mask_clr;
    i_mask_clear_op && !i_mask_set_op |=>
      (o_mask & $past(i_op_mask)) == 12'h000;
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("mask bits not cleared");
  property p_enable;
    i_irq_enable_op |=> o_irq_enabled;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable did not take");
  property p_absent;
    i_interrupt_sense_op |=> (o_sense_equip & $past(absent)) == $past(absent);
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent channel sensed idle");
  property p_save_clr;
    i_cond_to_acc_op && !i_irq_enable_op |=> o_cond == 6'h00;
  endproperty
  a_save_clr: assert property (p_save_clr)
    else $error("condition not cleared by save");
  c_entry: cover property (o_entry_done);
  c_sense: cover property (i_interrupt_sense_op);
  c_save: cover property (i_cond_to_acc_op ##1 o_cond == 6'h00);
endmodule // cipu_unit_props

bind cipu_unit cipu_unit_props #(.N_CHAN(N_CHAN), .N_LINE(N_LINE)) props_i (
  .i_mclk, .i_sys_rst, .i_chan_present, .i_exec_int, .i_pc, .i_op_mask,
  .i_mask_set_op, .i_mask_clear_op, .i_interrupt_sense_op,
  .i_irq_enable_op, .i_cond_to_acc_op, .o_sense_equip, .o_mask, .o_cond,
  .o_irq_enabled, .o_monitor_state, .o_mem_write, .o_mem_bitmask,
  .o_entry_done
);

//--- verif/tb_cipu_unit.sv
/*
  Self-checking bench for cipu_unit with the channel model.
  Assumes a 200 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "cipu_regs.svh"
module tb_cipu_unit;
  import cipu_pkg::*;
  typedef struct packed {
    logic set;
    logic [11:0] opnd;
    logic [11:0] exp;
  } cipu_row_t;
  localparam int MS = 0, MCL = 1, SN = 2, CS = 3, CA = 4, IC = 5;
  localparam int EN = 6, DI = 7, SV = 8, CC = 14;
  cipu_row_t rows [5] = '{'{1'b1, 12'hFFF, 12'hFFF},
    '{1'b0, 12'h0F0, 12'hF0F}, '{1'b1, 12'h030, 12'hF3F},
    '{1'b0, 12'h800, 12'h73F}, '{1'b0, 12'hFFF, 12'h000}};
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [63:0] want = '0;
  logic [7:0] chan_want = '0;
  logic [7:0] present = 8'hFF;
  logic [63:0] line;
  logic [7:0] chan;
  cipu_int_t ev = '0;
  logic exec = 1'b0;
  logic recog = 1'b0;
  logic [14:0] pc = 15'h1234;
  logic [11:0] opnd = '0;
  logic [23:0] ops = '0;
  logic [23:0] o_acc_data;
  logic [63:0] o_sense_equip;
  logic [7:0] o_sense_chan;
  logic [11:0] o_mask;
  logic [5:0] o_cond;
  logic o_irq_enabled;
  logic o_monitor_state;
  logic o_int_pending;
  cipu_entry_t o_mem_write;
  logic [11:0] o_mem_bitmask;
  logic o_entry_done;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;

  cipu_chan_model cipu_chan_model_i (.i_mclk, .i_present(present),
    .i_want(want), .i_chan_want(chan_want), .o_equip_line(line),
    .o_chan_int(chan));
  cipu_unit cipu_unit_i (.i_mclk, .i_sys_rst, .i_equip_line(line),
    .i_chan_int(chan), .i_chan_present(present), .i_int_event(ev),
    .i_exec_int(exec), .i_master_clear_request(ops[9]),
    .i_internal_clear_request(ops[10]), .i_external_clear_request(ops[11]),
    .i_recog_point(recog), .i_trap_exit_jump(ops[12]), .i_pc(pc),
    .i_op_mask(opnd), .i_mask_set_op(ops[0]), .i_mask_clear_op(ops[1]),
    .i_interrupt_sense_op(ops[2]), .i_internal_sense_op(ops[13]),
    .i_combined_sense_op(ops[3]), .i_clear_all_op(ops[4]),
    .i_io_clear_op(ops[5]), .i_channel_clear_op(ops[14]),
    .i_equip_select_op(ops[15]), .i_equip_sel_idx(opnd[5:0]),
    .i_irq_enable_op(ops[6]), .i_irq_disable_op(ops[7]),
    .i_cond_to_acc_op(ops[8]), .i_acc_to_cond_op(ops[16]),
    .i_acc_cond(opnd[5:0]), .i_boundary_jump_set_op(ops[17]),
    .i_destructive_load_set_op(ops[18]), .i_relocate_operands_op(ops[19]),
    .i_relocation_off_op(ops[20]), .i_load_acc_op(ops[21]),
    .i_jump_op(ops[22]), .i_jump_to_program(ops[23]), .o_acc_data,
    .o_sense_equip, .o_sense_chan, .o_mask, .o_cond, .o_irq_enabled,
    .o_monitor_state, .o_int_pending, .o_mem_write, .o_mem_bitmask,
    .o_entry_done);

  initial
  begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  task tick;
    @(posedge i_mclk);
    #1;
  endtask

  // Two ticks per pulse so no driver touches ops twice in one step.
  task pulse(input int b);
    ops[b] = 1'b1;
    tick;
    ops = '0;
    tick;
  endtask

  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task entry(input logic [11:0] code);
    int n;
    n = 0;
    recog = 1'b1;
    while (o_mem_write.valid !== 1'b1 && n < 20)
    begin
      tick;
      n++;
    end
    chk("ret", 64'({o_mem_write.addr, o_mem_write.code}),
      64'({`CIPU_RET_ADDR, pc[11:0]}));
    tick;
    chk("code", 64'({o_mem_write.addr, o_mem_write.code}),
      64'({`CIPU_CODE_ADDR, code}));
    chk("done", 64'({o_entry_done, o_mem_bitmask}), 64'(13'h1FFF));
    recog = 1'b0;
    tick;
    chk("ien_mon", 64'({o_irq_enabled, o_monitor_state}), 64'(1));
    pulse(SV);
    chk("cond", 64'(o_cond), 64'(0));
  endtask

  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      end_sim;
    end
  end

  initial
  begin
    repeat (3) tick;
    i_sys_rst = 1'b0;
    for (int r = 0; r < 5; r++)
    begin
      opnd = rows[r].opnd;
      pulse(rows[r].set ? MS : MCL);
      chk("mask", 64'(o_mask), 64'(rows[r].exp));
      pulse(CS);
      chk("acc", 64'(o_acc_data[23:12]), 64'(rows[r].exp));
    end
    $display("test mask done");
    present = 8'h0F;
    want = 64'h5;
    repeat (4) tick;
    pulse(SN);
    chk("sense", o_sense_equip, {32'hFFFF_FFFF, 32'h5});
    chk("sense_ch", 64'(o_sense_chan), 64'(8'hF0));
    present = 8'hFF;
    want = '0;
    repeat (4) tick;
    $display("test sense done");
    opnd = 12'hFFF;
    pulse(MS);
    pulse(IC);
    want = 64'h0260_0000;
    repeat (4) tick;
    pulse(EN);
    entry({6'h00, 3'd5, 3'd2});
    want = '0;
    repeat (4) tick;
    pulse(IC);
    chk("io_clr", 64'(o_int_pending), 64'(0));
    $display("test equip done");
    want = 64'h1;
    ev.arith_ovf = 1'b1;
    tick;
    ev = '0;
    repeat (3) tick;
    pulse(EN);
    entry(`CIPU_CODE_INTB);
    want = '0;
    repeat (4) tick;
    pulse(CA);
    pulse(IC);
    chk("all_clr", 64'(o_int_pending), 64'(0));
    chan_want = 8'h02;
    repeat (4) tick;
    pulse(EN);
    entry(`CIPU_CODE_CHAN | 12'h001);
    chan_want = '0;
    repeat (4) tick;
    pulse(CC);
    chk("ch_clr", 64'(o_int_pending), 64'(0));
    $display("test internal done");
    pulse(MCL);
    ev.manual = 1'b1;
    tick;
    ev = '0;
    pulse(EN);
    entry(`CIPU_CODE_INTB + 12'h006);
    chk("manual", 64'(o_int_pending), 64'(0));
    pulse(EN);
    pulse(DI);
    chk("dis", 64'(o_irq_enabled), 64'(0));
    exec = 1'b1;
    entry(12'h057);
    exec = 1'b0;
    $display("test exec done");
    pulse(MS);
    pulse(EN);
    i_sys_rst = 1'b1;
    repeat (3) tick;
    i_sys_rst = 1'b0;
    tick;
    chk("rst", 64'({o_mask, o_cond, o_irq_enabled}), 64'(0));
    $display("test reset done");
    end_sim;
  end
endmodule // tb_cipu_unit
